/* File: hw/rpm_pkg.sv */
// Package: constants for the reset and power-mode control block.
// Assumes an AXI4-Lite master on the 40 MHz core clock mclk.
package rpm_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] CAUSE_ADDR  = 8'h00;
  localparam logic [7:0] CFG_ADDR    = 8'h04;
  localparam logic [7:0] PMODE_ADDR  = 8'h08;
  localparam logic [7:0] STATUS_ADDR = 8'h0C;

  // ****************************************
  // Reset-cause field positions
  // ****************************************
  localparam int CAUSE_PIN  = 0;
  localparam int CAUSE_POR  = 1;
  localparam int CAUSE_BOD  = 2;
  localparam int CAUSE_WDT  = 3;
  localparam int CAUSE_SW   = 4;
  localparam int CAUSE_BRK  = 5;
  localparam int NUM_CAUSES = 6;

  // Config field positions
  localparam int CFG_BOD_EN   = 0;
  localparam int CFG_BOD_IRQ  = 1;
  localparam int CFG_PIN_EN   = 2;
  localparam int CFG_BOOT_ST0 = 3;
  localparam int CFG_RC_SYS   = 4;
  localparam int CFG_RTC_EN   = 5;
  localparam int CFG_XTAL     = 6;
  localparam int CFG_CMP_OFF  = 7;
  localparam int CFG_VEC_LSB  = 8;
  localparam int CFG_W        = 16;

  // Reset values
  localparam logic [CFG_W-1:0]      CFG_RESET   = 16'h0005;
  localparam logic [NUM_CAUSES-1:0] CAUSE_POWER = 6'h06;
  localparam logic [7:0]            VEC_RESET   = 8'h1F;

  // Power-mode command codes
  localparam logic [1:0] PM_RUN   = 2'h0;
  localparam logic [1:0] PM_IDLE  = 2'h1;
  localparam logic [1:0] PM_PD    = 2'h2;
  localparam logic [1:0] PM_TOTAL = 2'h3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int WAKE_XTAL_CYC = 992;
  localparam int WAKE_RC_CYC   = 224;
  localparam int WAKE_EXTRA_US = 60;
  localparam int CLK_MHZ       = 40;
  localparam int WAKE_EXTRA_CYC = WAKE_EXTRA_US * CLK_MHZ;
  localparam int WAKE_W        = 13;
  localparam int RST_STRETCH   = 4;

endpackage : rpm_pkg

/* File: hw/reset_sync.sv */
// Two-flop synchroniser for one asynchronous level.
// Assumes the level may change at any time relative to mclk.
module reset_sync (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // Level
  input  wire logic din,
  output logic      dout
);
  logic stage1_r;
  logic stage2_r;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
    end else begin
      stage1_r <= din;
      stage2_r <= stage1_r;
    end
  end

  assign dout = stage2_r;
endmodule : reset_sync

/* File: hw/reset_power_mode_control.sv */
// Reset gathering, cause flags, brownout and power modes, AXI4-Lite slave.
// Assumes resetn is the power-on event and all detector inputs are asynchronous.
// Operation
// - Brownout resets by default; config bit turns it into interrupt instead.
// - Software enables brownout detection; disabled means no reset, no interrupt.
// - Brownout condition follows the supply-low indication while enabled.
// - Power-on flag set at power-up, held until software clears it.
// - Idle halts core, peripherals run; enabled interrupt or reset ends it.
// - Power-down stops oscillator; exit only on reset or wake interrupts.
// - Brownout, watchdog, comparators, system timer keep running in power-down.
// - RC oscillator stops in power-down unless RC system clock with timer.
// - Total power-down also turns off brownout detection and comparators.
// - Pin enable 1 makes shared pin active-low reset, else plain input.
// - During power-up the pin always resets; nothing else overrides enable.
// - Six sources merge into core reset.
// - Each source has a cause flag; writing 0 clears it.
// - Power-on sets power-on and brownout flags, clears the others.
// - Other resets set own flag and keep earlier uncleared ones.
// - Fetch starts at zero or boot vector high byte with low 00h.
// - Boot address after break reset, boot status bit, or forced programming.
// - Enabled external interrupt wakes from idle or power-down.
// - Power-down wake holds clock 992 or 224 oscillator cycles plus fixed delay.
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
module reset_power_mode_control
  import rpm_pkg::*;
(
  // Clock and power-on reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Asynchronous reset and detector inputs
  input  wire logic        sharedResetPin,
  input  wire logic        supplyLow,
  input  wire logic        watchdogReset,
  input  wire logic        breakDetect,
  input  wire logic        ispForced,
  // Interrupt and oscillator tick inputs, same clock
  input  wire logic        extIrqRequestFlag,
  input  wire logic        wakeIrq,
  input  wire logic        anyEnabledIrq,
  input  wire logic        oscTick,
  // Outputs
  output logic             coreResetn,
  output logic             coreHalt,
  output logic             coreClockEn,
  output logic             oscEnable,
  output logic             rcOscEnable,
  output logic             bodPowered,
  output logic             cmpPowered,
  output logic             brownoutIrq,
  output logic             pinDigitalIn,
  output logic [15:0]      resetVector
);

  // ****************************************
  // Synchronisers
  // ****************************************
  logic pinS, lowS, wdtS, brkS, ispS;

  reset_sync u_pin (.mclk(mclk), .resetn(resetn), .din(~sharedResetPin), .dout(pinS));
  reset_sync u_low (.mclk(mclk), .resetn(resetn), .din(supplyLow), .dout(lowS));
  reset_sync u_wdt (.mclk(mclk), .resetn(resetn), .din(watchdogReset), .dout(wdtS));
  reset_sync u_brk (.mclk(mclk), .resetn(resetn), .din(breakDetect), .dout(brkS));
  reset_sync u_isp (.mclk(mclk), .resetn(resetn), .din(ispForced), .dout(ispS));

  typedef enum logic [3:0] {
    ST_POWERUP = 4'b0001,
    ST_RUN     = 4'b0010,
    ST_SLEEP   = 4'b0100,
    ST_WAKE    = 4'b1000
  } pstate_e;

  // ****************************************
  // State
  // ****************************************
  pstate_e                 state_r, state_nxt;
  logic [1:0]              mode_r, mode_nxt;
  logic [CFG_W-1:0]        cfg_r, cfg_nxt;
  logic [NUM_CAUSES-1:0]   cause_r, cause_nxt;
  logic [WAKE_W-1:0]       wake_r, wake_nxt;
  logic [2:0]              stretch_r, stretch_nxt;
  // Low while counting oscillator ticks, high during the fixed delay
  logic                    wakePhase_r, wakePhase_nxt;
  logic                    swReset_r, swReset_nxt;
  logic                    bootSel_r, bootSel_nxt;
  logic                    awHeld_r, awHeld_nxt;
  logic                    wHeld_r, wHeld_nxt;
  logic [7:0]              awAddr_r, awAddr_nxt;
  logic [31:0]             wData_r, wData_nxt;
  logic                    bvalid_r, bvalid_nxt;
  logic [1:0]              bresp_r, bresp_nxt;
  logic                    rvalid_r, rvalid_nxt;
  logic [31:0]             rdata_r, rdata_nxt;
  logic [1:0]              rresp_r, rresp_nxt;
  logic                    coreRstn_r, coreRstn_nxt;
  logic                    haltOut_r, clkEnOut_r, oscOut_r, rcOut_r;
  logic                    bodOut_r, cmpOut_r, bodIrqOut_r, pinInOut_r;
  logic [15:0]             vecOut_r;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == CAUSE_ADDR) || (a == CFG_ADDR) || (a == PMODE_ADDR) ||
             (a == STATUS_ADDR);
  endfunction : mapped

  // ****************************************
  // Derived conditions
  // ****************************************
  logic inPowerDown, bodOn, brownout, pinReset, wrFire, wakeEvent;
  logic [NUM_CAUSES-1:0] srcActive;
  logic [WAKE_W-1:0] wakeLoad;

  assign inPowerDown = (state_r == ST_SLEEP) && (mode_r != PM_IDLE);
  // Detector dark in total power-down
  assign bodOn    = cfg_r[CFG_BOD_EN] && !(inPowerDown && mode_r == PM_TOTAL);
  assign brownout = bodOn && lowS;
  // Power-up phase ignores the enable bit
  assign pinReset = pinS && (cfg_r[CFG_PIN_EN] || state_r == ST_POWERUP);

  always_comb begin
    srcActive = '0;
    srcActive[CAUSE_PIN] = pinReset;
    srcActive[CAUSE_BOD] = brownout && !cfg_r[CFG_BOD_IRQ];
    srcActive[CAUSE_WDT] = wdtS;
    srcActive[CAUSE_SW]  = swReset_r;
    srcActive[CAUSE_BRK] = brkS;
  end

  assign wakeEvent = (mode_r == PM_IDLE) ? anyEnabledIrq
                                         : (wakeIrq || extIrqRequestFlag);
  assign wakeLoad  = cfg_r[CFG_XTAL] ? WAKE_W'(WAKE_XTAL_CYC) : WAKE_W'(WAKE_RC_CYC);
  assign wrFire    = awHeld_r && wHeld_r && !bvalid_r;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    state_nxt   = state_r;
    mode_nxt    = mode_r;
    cfg_nxt     = cfg_r;
    cause_nxt   = cause_r;
    wake_nxt    = wake_r;
    stretch_nxt = stretch_r;
    wakePhase_nxt = wakePhase_r;
    swReset_nxt = 1'b0;
    bootSel_nxt = bootSel_r;
    awHeld_nxt  = awHeld_r;
    wHeld_nxt   = wHeld_r;
    awAddr_nxt  = awAddr_r;
    wData_nxt   = wData_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    coreRstn_nxt = coreRstn_r;

    // Bus channels
    if (awvalid && !awHeld_r) begin
      awHeld_nxt = 1'b1;
      awAddr_nxt = awaddr;
    end
    if (wvalid && !wHeld_r) begin
      wHeld_nxt = 1'b1;
      wData_nxt = wdata & {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
    end
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (wrFire) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = mapped(awAddr_r) ? 2'h0 : 2'h2;
      // Clear-only: a 0 clears, a 1 leaves the flag alone
      if (awAddr_r == CAUSE_ADDR) begin
        cause_nxt = cause_r & wData_r[NUM_CAUSES-1:0];
      end else if (awAddr_r == CFG_ADDR) begin
        cfg_nxt = wData_r[CFG_W-1:0];
      end else if (awAddr_r == PMODE_ADDR) begin
        mode_nxt    = wData_r[1:0];
        swReset_nxt = wData_r[4];
        if (wData_r[1:0] != PM_RUN && state_r == ST_RUN) begin
          state_nxt = ST_SLEEP;
        end
      end
    end
    if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    if (arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = mapped(araddr) ? 2'h0 : 2'h2;
      rdata_nxt  = '0;
      if (araddr == CAUSE_ADDR) begin
        rdata_nxt[NUM_CAUSES-1:0] = cause_r;
      end else if (araddr == CFG_ADDR) begin
        rdata_nxt[CFG_W-1:0] = cfg_r;
      end else if (araddr == PMODE_ADDR) begin
        rdata_nxt[1:0] = mode_r;
      end else if (araddr == STATUS_ADDR) begin
        rdata_nxt[3:0] = {brownout, pinS, coreRstn_r, state_r == ST_SLEEP};
      end
    end

    // Set wins over a clear in the same cycle
    cause_nxt = cause_nxt | srcActive;

    // Stretch reset; release only when every source is idle
    if (|srcActive) begin
      stretch_nxt  = 3'(RST_STRETCH);
      coreRstn_nxt = 1'b0;
      bootSel_nxt  = brkS;
    end else if (stretch_r != 3'h0) begin
      stretch_nxt = stretch_r - 3'h1;
    end else begin
      coreRstn_nxt = 1'b1;
    end
    if (|srcActive && state_r != ST_POWERUP) begin
      state_nxt = ST_RUN;
      mode_nxt  = PM_RUN;
    end

    case (state_r)
      ST_POWERUP: begin
        if (!pinS && stretch_r == 3'h0 && !(|srcActive)) begin
          state_nxt = ST_RUN;
        end
      end
      ST_SLEEP: begin
        if (wakeEvent && !(|srcActive)) begin
          if (mode_r == PM_IDLE) begin
            state_nxt = ST_RUN;
          end else begin
            state_nxt = ST_WAKE;
            wake_nxt  = wakeLoad;
            wakePhase_nxt = 1'b0;
          end
          mode_nxt = PM_RUN;
        end
      end
      ST_WAKE: begin
        // Oscillator ticks first, then the fixed delay in core cycles
        if (!wakePhase_r) begin
          if (oscTick) begin
            if (wake_r <= WAKE_W'(1)) begin
              wake_nxt      = WAKE_W'(WAKE_EXTRA_CYC);
              wakePhase_nxt = 1'b1;
            end else begin
              wake_nxt = wake_r - WAKE_W'(1);
            end
          end
        end else if (wake_r == '0) begin
          state_nxt = ST_RUN;
        end else begin
          wake_nxt = wake_r - WAKE_W'(1);
        end
      end
      default: begin
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r    <= ST_POWERUP;
      mode_r     <= PM_RUN;
      cfg_r      <= CFG_RESET;
      cause_r    <= CAUSE_POWER;
      wake_r     <= '0;
      stretch_r  <= 3'(RST_STRETCH);
      wakePhase_r <= 1'b0;
      swReset_r  <= 1'b0;
      bootSel_r  <= 1'b0;
      awHeld_r   <= 1'b0;
      wHeld_r    <= 1'b0;
      awAddr_r   <= '0;
      wData_r    <= '0;
      bvalid_r   <= 1'b0;
      bresp_r    <= 2'h0;
      rvalid_r   <= 1'b0;
      rdata_r    <= '0;
      rresp_r    <= 2'h0;
      coreRstn_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      mode_r     <= mode_nxt;
      cfg_r      <= cfg_nxt;
      cause_r    <= cause_nxt;
      wake_r     <= wake_nxt;
      stretch_r  <= stretch_nxt;
      wakePhase_r <= wakePhase_nxt;
      swReset_r  <= swReset_nxt;
      bootSel_r  <= bootSel_nxt;
      awHeld_r   <= awHeld_nxt;
      wHeld_r    <= wHeld_nxt;
      awAddr_r   <= awAddr_nxt;
      wData_r    <= wData_nxt;
      bvalid_r   <= bvalid_nxt;
      bresp_r    <= bresp_nxt;
      rvalid_r   <= rvalid_nxt;
      rdata_r    <= rdata_nxt;
      rresp_r    <= rresp_nxt;
      coreRstn_r <= coreRstn_nxt;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  logic sleepNxt, pdNxt, totNxt, ispLatch_r;

  assign sleepNxt = (state_nxt == ST_SLEEP);
  assign pdNxt    = sleepNxt && (mode_nxt != PM_IDLE);
  assign totNxt   = sleepNxt && (mode_nxt == PM_TOTAL);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      haltOut_r   <= 1'b1;
      clkEnOut_r  <= 1'b0;
      oscOut_r    <= 1'b1;
      rcOut_r     <= 1'b1;
      bodOut_r    <= 1'b1;
      cmpOut_r    <= 1'b1;
      bodIrqOut_r <= 1'b0;
      pinInOut_r  <= 1'b1;
      vecOut_r    <= 16'h0000;
      ispLatch_r  <= 1'b0;
    end else begin
      // Power-up strap sampled every cycle while still in ST_POWERUP, before core release
      if (state_r == ST_POWERUP) begin
        ispLatch_r <= ispS;
      end
      haltOut_r   <= sleepNxt || state_nxt == ST_WAKE;
      clkEnOut_r  <= (state_nxt == ST_RUN);
      oscOut_r    <= !pdNxt;
      rcOut_r     <= !pdNxt || (cfg_nxt[CFG_RC_SYS] && cfg_nxt[CFG_RTC_EN]);
      bodOut_r    <= cfg_nxt[CFG_BOD_EN] && !totNxt;
      cmpOut_r    <= !totNxt && !cfg_nxt[CFG_CMP_OFF];
      bodIrqOut_r <= brownout && cfg_r[CFG_BOD_IRQ];
      pinInOut_r  <= !pinS;
      vecOut_r    <= (bootSel_r || cfg_r[CFG_BOOT_ST0] || ispLatch_r) ?
                     {cfg_r[CFG_VEC_LSB +: 8], 8'h00} : 16'h0000;
    end
  end

  assign awready     = !awHeld_r;
  assign wready      = !wHeld_r;
  assign bvalid      = bvalid_r;
  assign bresp       = bresp_r;
  assign arready     = !rvalid_r;
  assign rvalid      = rvalid_r;
  assign rdata       = rdata_r;
  assign rresp       = rresp_r;
  assign coreResetn  = coreRstn_r;
  assign coreHalt    = haltOut_r;
  assign coreClockEn = clkEnOut_r;
  assign oscEnable   = oscOut_r;
  assign rcOscEnable = rcOut_r;
  assign bodPowered  = bodOut_r;
  assign cmpPowered  = cmpOut_r;
  assign brownoutIrq = bodIrqOut_r;
  assign pinDigitalIn = pinInOut_r;
  assign resetVector = vecOut_r;

endmodule : reset_power_mode_control

/* File: tb/rpm_monitor.sv */
// Assertion checker for the reset and power-mode block.
// Assumes it is bound to reset_power_mode_control and sees its ports only.
module rpm_monitor
  import rpm_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        resetn,
  // Watched inputs
  input wire logic        watchdogReset,
  input wire logic        breakDetect,
  input wire logic        anyEnabledIrq,
  input wire logic        sharedResetPin,
  // Watched outputs
  input wire logic        coreResetn,
  input wire logic        coreHalt,
  input wire logic        coreClockEn,
  input wire logic        oscEnable,
  input wire logic        bodPowered,
  input wire logic        brownoutIrq,
  input wire logic        pinDigitalIn,
  input wire logic [15:0] resetVector
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Helper state
  // ****************************************
  // Small margin for skew between oscillator enable and tick counting
  localparam int WAKE_MIN = WAKE_RC_CYC + WAKE_EXTRA_CYC - 20;
  logic        powerUp_r, powerUp_nxt, pdSeen_r, pdSeen_nxt;
  logic [15:0] wakeCnt_r, wakeCnt_nxt;

  always_comb begin
    powerUp_nxt = powerUp_r && !coreResetn;
    pdSeen_nxt  = coreResetn && (!oscEnable || (pdSeen_r && !coreClockEn));
    wakeCnt_nxt = (pdSeen_r && oscEnable) ? wakeCnt_r + 16'h0001 : 16'h0000;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      powerUp_r <= 1'b1;
      pdSeen_r  <= 1'b0;
      wakeCnt_r <= 16'h0000;
    end else begin
      powerUp_r <= powerUp_nxt;
      pdSeen_r  <= pdSeen_nxt;
      wakeCnt_r <= wakeCnt_nxt;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  AST_WDT_RESET: assert property ($rose(watchdogReset) |-> ##[1:6] !coreResetn)
    else $error("watchdog request did not reset core");
  AST_BRK_RESET: assert property ($rose(breakDetect) |-> ##[1:6] !coreResetn)
    else $error("break request did not reset core");
  AST_RELEASE: assert property ($rose(coreResetn) |->
    !$past(watchdogReset, 3) && !$past(breakDetect, 3))
    else $error("core released while a source was active");
  AST_PWRUP_PIN: assert property (powerUp_r && !pinDigitalIn |=> !coreResetn)
    else $error("core left power-up with pin low");
  AST_PIN_SYNC: assert property (($stable(sharedResetPin)) [*5] |->
    pinDigitalIn == sharedResetPin)
    else $error("pin input does not follow pin");
  AST_PD_HALT: assert property (coreResetn && !oscEnable |-> coreHalt)
    else $error("core running with oscillator stopped");
  AST_BOD_IRQ: assert property ((!bodPowered) [*2] |-> !brownoutIrq)
    else $error("brownout interrupt with detector off");
  AST_WAKE: assert property ($rose(coreClockEn) && pdSeen_r |-> wakeCnt_r >= WAKE_MIN)
    else $error("core clock back too early after power-down");
  AST_VEC_LOW: assert property (resetVector[7:0] == 8'h00)
    else $error("reset vector low byte not zero");
  AST_IDLE_EXIT: assert property (coreResetn && coreHalt && oscEnable && !pdSeen_r
    && anyEnabledIrq |-> ##[1:4] !coreHalt)
    else $error("idle not ended by interrupt");

  COV_RESET: cover property ($rose(coreResetn));
  COV_PD: cover property ($fell(oscEnable));
  COV_IRQ: cover property ($rose(brownoutIrq));
endmodule : rpm_monitor

bind reset_power_mode_control rpm_monitor rpm_monitor_i (
  .mclk(mclk), .resetn(resetn), .watchdogReset(watchdogReset),
  .breakDetect(breakDetect), .anyEnabledIrq(anyEnabledIrq),
  .sharedResetPin(sharedResetPin), .coreResetn(coreResetn),
  .coreHalt(coreHalt), .coreClockEn(coreClockEn), .oscEnable(oscEnable),
  .bodPowered(bodPowered), .brownoutIrq(brownoutIrq), .pinDigitalIn(pinDigitalIn),
  .resetVector(resetVector)
);

/* File: tb/tb.sv */
// Self-checking bench for the reset and power-mode block.
// Assumes the hand-over bus and wake timing; checker is bound separately.
module tb
  import rpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk = 1'b0, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, ispForced, oscTick;
  logic        sharedResetPin, supplyLow, watchdogReset, breakDetect;
  logic        extIrqRequestFlag, wakeIrq, anyEnabledIrq, coreResetn, coreHalt;
  logic        coreClockEn, oscEnable, rcOscEnable, bodPowered, cmpPowered;
  logic        brownoutIrq, pinDigitalIn, bootSt, rcKeep;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [31:0] seed = 32'd67201;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [15:0] resetVector;
  int          n_fail = 0, checks = 0, cause;
  int          src[5] = '{CAUSE_WDT, CAUSE_PIN, CAUSE_BOD, CAUSE_BRK, CAUSE_SW};

  reset_power_mode_control reset_power_mode_control_i (.mclk, .resetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .sharedResetPin, .supplyLow,
    .watchdogReset, .breakDetect, .ispForced, .extIrqRequestFlag, .wakeIrq,
    .anyEnabledIrq, .oscTick, .coreResetn, .coreHalt, .coreClockEn, .oscEnable,
    .rcOscEnable, .bodPowered, .cmpPowered, .brownoutIrq, .pinDigitalIn, .resetVector);

  always #12.5 mclk = ~mclk;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Random oscillator ticks stretch the wake count unevenly
  always @(posedge mclk) begin
    seed = xs(seed);
    oscTick <= seed[0];
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic waitCore(input logic v);
    int i;
    i = 0;
    while (coreResetn !== v && i < 200) begin
      @(posedge mclk);
      i++;
    end
    chk("coreResetn", v, coreResetn);
  endtask : waitCore

  task automatic srcRst(input int k);
    logic [15:0] v;
    v = (k == CAUSE_BRK || bootSt) ? 16'h1200 : 16'h0000;
    d = {26'h0, seed[13:8]};
    wr(CAUSE_ADDR, d);
    cause &= d;
    if (k == CAUSE_SW) wr(PMODE_ADDR, 32'h0000_0010);
    sharedResetPin <= (k != CAUSE_PIN);
    supplyLow <= (k == CAUSE_BOD);
    watchdogReset <= (k == CAUSE_WDT);
    breakDetect <= (k == CAUSE_BRK);
    waitCore(1'b0);
    sharedResetPin <= 1'b1;
    supplyLow <= 1'b0;
    watchdogReset <= 1'b0;
    breakDetect <= 1'b0;
    waitCore(1'b1);
    cause |= 1 << k;
    rd(CAUSE_ADDR);
    chk("cause", cause, d);
    chk("resetVector", v, resetVector);
  endtask : srcRst

  task automatic bod(input logic [31:0] c, input logic e);
    wr(CFG_ADDR, c);
    supplyLow <= 1'b1;
    repeat (10) @(posedge mclk);
    chk("brownoutIrq", e, brownoutIrq);
    chk("coreResetn", 1, coreResetn);
    supplyLow <= 1'b0;
    repeat (10) @(posedge mclk);
    chk("brownoutIrq", 0, brownoutIrq);
  endtask : bod

  task automatic sleep(input logic [1:0] m);
    int i;
    wr(PMODE_ADDR, {30'h0, m});
    repeat (4) @(posedge mclk);
    chk("coreHalt", 1, coreHalt);
    chk("coreClockEn", 0, coreClockEn);
    chk("oscEnable", m == PM_IDLE, oscEnable);
    chk("rcOscEnable", m == PM_IDLE || rcKeep, rcOscEnable);
    chk("bodPowered", m != PM_TOTAL, bodPowered);
    chk("cmpPowered", m != PM_TOTAL, cmpPowered);
    anyEnabledIrq <= (m == PM_IDLE);
    wakeIrq <= (m == PM_PD);
    extIrqRequestFlag <= (m == PM_TOTAL);
    i = 0;
    while (coreHalt !== 1'b0 && i < 5000) begin
      @(posedge mclk);
      i++;
    end
    anyEnabledIrq <= 1'b0;
    wakeIrq <= 1'b0;
    extIrqRequestFlag <= 1'b0;
    chk("coreHalt", 0, coreHalt);
    chk("coreClockEn", 1, coreClockEn);
    chk("wakeDelay", m != PM_IDLE, i >= WAKE_RC_CYC + WAKE_EXTRA_CYC);
  endtask : sleep

  task automatic test_done;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    #1500000;
    n_fail++;
    test_done();
  end

  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready, supplyLow, watchdogReset} = 8'h00;
    {breakDetect, ispForced, extIrqRequestFlag, wakeIrq, anyEnabledIrq} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    sharedResetPin = 1'b1;
    wstrb = 4'hF;
    bootSt = 1'b0;
    rcKeep = 1'b0;
    repeat (5) @(posedge mclk);
    chk("coreResetn", 0, coreResetn);
    resetn <= 1'b1;
    waitCore(1'b1);
    cause = 6;
    rd(CAUSE_ADDR);
    chk("cause", cause, d);
    rd(CFG_ADDR);
    chk("config", CFG_RESET, d);
    rd(8'h10);
    chk("rresp", 2'h2, r);
    wr(8'h20, 32'h0);
    chk("bresp", 2'h2, r);
    wr(CFG_ADDR, 32'h0000_1205);
    foreach (src[j]) srcRst(src[j]);
    bootSt = 1'b1;
    wr(CFG_ADDR, 32'h0000_120D);
    srcRst(CAUSE_WDT);
    bootSt = 1'b0;
    wr(CFG_ADDR, 32'h0000_1201);
    sharedResetPin <= 1'b0;
    repeat (10) @(posedge mclk);
    chk("coreResetn", 1, coreResetn);
    chk("pinDigitalIn", 0, pinDigitalIn);
    sharedResetPin <= 1'b1;
    bod(32'h0000_1203, 1'b1);
    bod(32'h0000_1200, 1'b0);
    wr(CFG_ADDR, 32'h0000_1201);
    sleep(PM_IDLE);
    sleep(PM_PD);
    rcKeep = 1'b1;
    wr(CFG_ADDR, 32'h0000_1231);
    sleep(PM_PD);
    sleep(PM_TOTAL);
    resetn <= 1'b0;
    sharedResetPin <= 1'b0;
    ispForced <= 1'b1;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (20) @(posedge mclk);
    chk("coreResetn", 0, coreResetn);
    sharedResetPin <= 1'b1;
    waitCore(1'b1);
    rd(CAUSE_ADDR);
    chk("cause", CAUSE_POWER | (6'h01 << CAUSE_PIN), d);
    wr(CFG_ADDR, 32'h0000_1205);
    @(posedge mclk);
    chk("resetVector", 16'h1200, resetVector);
    test_done();
  end
endmodule : tb
